// ### hdl/ccr_consts.svh
// Offsets, field positions, reset values and table figures for the
// converter core control register bank.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// Printed offsets are not all multiples of four: these are indices,
// byte address is four times the index, word address equals the index.
`define CCR_IDX_TWO_A        8'h06
`define CCR_IDX_TWO_B        8'h07
`define CCR_IDX_THREE_A      8'h08
`define CCR_IDX_THREE_B      8'h09
`define CCR_IDX_TWO_VSET     8'h0e
`define CCR_IDX_TWO_FLOOR    8'h0f
`define CCR_IDX_THREE_VSET   8'h10
`define CCR_IDX_THREE_FLOOR  8'h11

`define CCR_BIT_ON           3'h7
`define CCR_BIT_GATING       3'h6
`define CCR_BIT_CHOICE       3'h5
`define CCR_BIT_PAIR_MODE    3'h4
`define CCR_BIT_BLEED        3'h3
`define CCR_BIT_FIXED_FREQ   3'h1
`define CCR_CAP_MSB          5
`define CCR_CAP_LSB          3
`define CCR_RAMP_MSB         2
`define CCR_RAMP_LSB         0

`define CCR_RST_A            8'he8
`define CCR_RST_B            8'h34
`define CCR_RST_VSET         8'h37
`define CCR_RST_FLOOR        8'h00
`define CCR_MASK_A           8'hfa
`define CCR_MASK_B           8'h3f

// Current cap in units of 0.5 A: code 2 gives 5 (2.5 A)
`define CCR_CAP_MIN_CODE     3'h2
`define CCR_CAP_OFFSET       4'h3

// Ramp rate in units of 0.01 mV/us, codes 0 to 7
`define CCR_RAMP_C0          12'hbb8
`define CCR_RAMP_C1          12'h5dc
`define CCR_RAMP_C2          12'h3e8
`define CCR_RAMP_C3          12'h2ee
`define CCR_RAMP_C4          12'h17c
`define CCR_RAMP_C5          12'h0be
`define CCR_RAMP_C6          12'h05e
`define CCR_RAMP_C7          12'h028

`define CCR_UNMAPPED_DATA    32'h00000000
`endif

// ### hdl/ccr_core_ctrl.sv
// Control register bank for converter cores two and three, Avalon-MM slave.
// Assumes a synchronous master and enable pins already synchronous to clk.
// Notes on behaviour
// - Bit 7 turns core on, resets one
// - Bit 6 gates core with chosen pin
// - Bit 5 picks pin, default second
// - Bit 4 makes pin roof/floor select
// - Floor state uses floor voltage setting
// - Bit 3 bleeds output while core off
// - Bit 1 forces fixed-frequency switching
// - Bits 5:3 set current cap, default 6
// - Current cap change applies while running
// - Bits 2:0 set ramp rate, default 4
// - Core three mirrors core two fields
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_consts.svh"
module ccr_core_ctrl (
   input  wire logic        clk_in,               // 10 MHz clock
   input  wire logic        sys_rst_in,           // Async reset, high
   input  wire logic [7:0]  avs_address_in,       // Word address
   input  wire logic        avs_read_in,          // Read request
   input  wire logic        avs_write_in,         // Write request
   input  wire logic [31:0] avs_writedata_in,     // Write data
   input  wire logic [3:0]  avs_byteenable_in,    // Byte enables
   output logic [31:0]      avs_readdata_out,     // Read data
   output logic             avs_waitrequest_out,  // Stall
   output logic [1:0]       avs_response_out,     // 00 ok, 11 unmapped
   input  wire logic        enable_input_first_in,  // First enable pin
   input  wire logic        enable_input_second_in, // Second enable pin
   output logic [1:0]       core_run_out,         // Core running
   output logic [1:0]       core_output_bleed_out, // Discharge path on
   output logic [1:0]       core_fixed_freq_out,  // Forced fixed freq
   output logic [1:0]       core_floor_sel_out,   // Floor state active
   output logic [15:0]      core_target_vset_out, // Target code, 2x8
   output logic [7:0]       core_cap_half_amps_out, // Cap in 0.5 A, 2x4
   output logic [23:0]      core_ramp_rate_out    // Ramp, 0.01 mV/us, 2x12
);

   // Index 0 is core two, 1 is core three
   logic [7:0] ctl_a [2];
   logic [7:0] ctl_b [2];
   logic [7:0] vset [2];
   logic [7:0] floor_set [2];
   logic [7:0] next_ctl_a [2];
   logic [7:0] next_ctl_b [2];
   logic [7:0] next_vset [2];
   logic [7:0] next_floor_set [2];

   ccr_pkg::ccr_bus_state_t state;
   ccr_pkg::ccr_bus_state_t next_state;
   logic [31:0]             rdata;
   logic [31:0]             next_rdata;
   logic [1:0]              resp;
   logic [1:0]              next_resp;

   logic [1:0] run;
   logic [1:0] next_run;
   logic [1:0] bleed;
   logic [1:0] next_bleed;
   logic [1:0] ffreq;
   logic [1:0] next_ffreq;
   logic [1:0] flsel;
   logic [1:0] next_flsel;
   logic [15:0] tgt;
   logic [15:0] next_tgt;
   logic [7:0]  cap;
   logic [7:0]  next_cap;
   logic [23:0] ramp;
   logic [23:0] next_ramp;

   function automatic logic [11:0] ramp_rate(input logic [2:0] code);
      case (code)
         3'h0: ramp_rate = `CCR_RAMP_C0;
         3'h1: ramp_rate = `CCR_RAMP_C1;
         3'h2: ramp_rate = `CCR_RAMP_C2;
         3'h3: ramp_rate = `CCR_RAMP_C3;
         3'h4: ramp_rate = `CCR_RAMP_C4;
         3'h5: ramp_rate = `CCR_RAMP_C5;
         3'h6: ramp_rate = `CCR_RAMP_C6;
         default: ramp_rate = `CCR_RAMP_C7;
      endcase
   endfunction : ramp_rate

   // Codes 0 and 1 are undefined; they clamp to the lowest cap
   function automatic logic [3:0] cap_half_amps(input logic [2:0] code);
      if (code < `CCR_CAP_MIN_CODE) begin
         cap_half_amps = 4'h5;
      end else begin
         cap_half_amps = {1'b0, code} + `CCR_CAP_OFFSET;
      end
   endfunction : cap_half_amps

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic       be,
                                        input logic [7:0] mask);
      merge = be ? (wd & mask) : old;
   endfunction : merge

   // Bus: every request answered one cycle after it is seen
   always_comb begin
      next_state = state;
      next_rdata = rdata;
      next_resp = resp;
      for (int i = 0; i < 2; i++) begin
         next_ctl_a[i] = ctl_a[i];
         next_ctl_b[i] = ctl_b[i];
         next_vset[i] = vset[i];
         next_floor_set[i] = floor_set[i];
      end
      case (state)
         ccr_pkg::CCR_IDLE: begin
            if (avs_read_in || avs_write_in) begin
               next_state = ccr_pkg::CCR_ANSWER;
               next_resp = 2'b00;
               next_rdata = `CCR_UNMAPPED_DATA;
               if (avs_address_in == `CCR_IDX_TWO_A) begin
                  next_rdata = {24'h000000, ctl_a[0]};
               end else if (avs_address_in == `CCR_IDX_TWO_B) begin
                  next_rdata = {24'h000000, ctl_b[0]};
               end else if (avs_address_in == `CCR_IDX_THREE_A) begin
                  next_rdata = {24'h000000, ctl_a[1]};
               end else if (avs_address_in == `CCR_IDX_THREE_B) begin
                  next_rdata = {24'h000000, ctl_b[1]};
               end else if (avs_address_in == `CCR_IDX_TWO_VSET) begin
                  next_rdata = {24'h000000, vset[0]};
               end else if (avs_address_in == `CCR_IDX_TWO_FLOOR) begin
                  next_rdata = {24'h000000, floor_set[0]};
               end else if (avs_address_in == `CCR_IDX_THREE_VSET) begin
                  next_rdata = {24'h000000, vset[1]};
               end else if (avs_address_in == `CCR_IDX_THREE_FLOOR) begin
                  next_rdata = {24'h000000, floor_set[1]};
               end else begin
                  next_resp = 2'b11;
               end
            end
         end
         default: begin
            next_state = ccr_pkg::CCR_IDLE;
            // Write lands on the edge the master sees waitrequest low
            // Reserved bits are masked to zero and read back as zero
            if (avs_write_in) begin
               if (avs_address_in == `CCR_IDX_TWO_A) begin
                  next_ctl_a[0] = merge(ctl_a[0], avs_writedata_in[7:0],
                     avs_byteenable_in[0], `CCR_MASK_A);
               end else if (avs_address_in == `CCR_IDX_TWO_B) begin
                  next_ctl_b[0] = merge(ctl_b[0], avs_writedata_in[7:0],
                     avs_byteenable_in[0], `CCR_MASK_B);
               end else if (avs_address_in == `CCR_IDX_THREE_A) begin
                  next_ctl_a[1] = merge(ctl_a[1], avs_writedata_in[7:0],
                     avs_byteenable_in[0], `CCR_MASK_A);
               end else if (avs_address_in == `CCR_IDX_THREE_B) begin
                  next_ctl_b[1] = merge(ctl_b[1], avs_writedata_in[7:0],
                     avs_byteenable_in[0], `CCR_MASK_B);
               end else if (avs_address_in == `CCR_IDX_TWO_VSET) begin
                  next_vset[0] = merge(vset[0], avs_writedata_in[7:0],
                     avs_byteenable_in[0], 8'hff);
               end else if (avs_address_in == `CCR_IDX_TWO_FLOOR) begin
                  next_floor_set[0] = merge(floor_set[0],
                     avs_writedata_in[7:0], avs_byteenable_in[0], 8'hff);
               end else if (avs_address_in == `CCR_IDX_THREE_VSET) begin
                  next_vset[1] = merge(vset[1], avs_writedata_in[7:0],
                     avs_byteenable_in[0], 8'hff);
               end else if (avs_address_in == `CCR_IDX_THREE_FLOOR) begin
                  next_floor_set[1] = merge(floor_set[1],
                     avs_writedata_in[7:0], avs_byteenable_in[0], 8'hff);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= ccr_pkg::CCR_IDLE;
         rdata <= 32'h00000000;
         resp <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            ctl_a[i] <= `CCR_RST_A;
            ctl_b[i] <= `CCR_RST_B;
            vset[i] <= `CCR_RST_VSET;
            floor_set[i] <= `CCR_RST_FLOOR;
         end
      end else begin
         state <= next_state;
         rdata <= next_rdata;
         resp <= next_resp;
         for (int i = 0; i < 2; i++) begin
            ctl_a[i] <= next_ctl_a[i];
            ctl_b[i] <= next_ctl_b[i];
            vset[i] <= next_vset[i];
            floor_set[i] <= next_floor_set[i];
         end
      end
   end

   // Core control decode, registered one cycle after the inputs change
   always_comb begin
      logic pin;
      logic gating;
      logic pair;
      pin = 1'b0;
      gating = 1'b0;
      pair = 1'b0;
      next_run = '0;
      next_bleed = '0;
      next_ffreq = '0;
      next_flsel = '0;
      next_tgt = '0;
      next_cap = '0;
      next_ramp = '0;
      for (int i = 0; i < 2; i++) begin
         pin = ctl_a[i][`CCR_BIT_CHOICE] ? enable_input_second_in
                                         : enable_input_first_in;
         gating = ctl_a[i][`CCR_BIT_GATING];
         pair = ctl_a[i][`CCR_BIT_PAIR_MODE];
         if (!gating) begin
            next_run[i] = ctl_a[i][`CCR_BIT_ON];
         end else if (!pair) begin
            next_run[i] = ctl_a[i][`CCR_BIT_ON] & pin;
         end else begin
            next_run[i] = ctl_a[i][`CCR_BIT_ON];
            // A core that is off has no floor state to show
            next_flsel[i] = ctl_a[i][`CCR_BIT_ON] & ~pin;
         end
         next_tgt[i*8 +: 8] = next_flsel[i] ? floor_set[i] : vset[i];
         next_bleed[i] = ~next_run[i] & ctl_a[i][`CCR_BIT_BLEED];
         next_ffreq[i] = ctl_a[i][`CCR_BIT_FIXED_FREQ];
         // No run qualifier: a new cap applies at once
         next_cap[i*4 +: 4] =
            cap_half_amps(ctl_b[i][`CCR_CAP_MSB:`CCR_CAP_LSB]);
         next_ramp[i*12 +: 12] =
            ramp_rate(ctl_b[i][`CCR_RAMP_MSB:`CCR_RAMP_LSB]);
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run <= '0;
         bleed <= '0;
         ffreq <= '0;
         flsel <= '0;
         tgt <= '0;
         cap <= '0;
         ramp <= '0;
      end else begin
         run <= next_run;
         bleed <= next_bleed;
         ffreq <= next_ffreq;
         flsel <= next_flsel;
         tgt <= next_tgt;
         cap <= next_cap;
         ramp <= next_ramp;
      end
   end

   assign avs_readdata_out = rdata;
   assign avs_response_out = resp;
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
                                (state == ccr_pkg::CCR_IDLE);
   assign core_run_out = run;
   assign core_output_bleed_out = bleed;
   assign core_fixed_freq_out = ffreq;
   assign core_floor_sel_out = flsel;
   assign core_target_vset_out = tgt;
   assign core_cap_half_amps_out = cap;
   assign core_ramp_rate_out = ramp;

endmodule : ccr_core_ctrl
`default_nettype wire

// ### hdl/ccr_pkg.sv
// Types shared by the converter core control register bank.
// Assumes the constants header sits beside it.
`include "ccr_consts.svh"
package ccr_pkg;
   typedef enum logic [1:0] {
      CCR_IDLE = 2'b00,
      CCR_ANSWER = 2'b01
   } ccr_bus_state_t;
endpackage : ccr_pkg

// ### sim/ccr_core_ctrl_checker.sv
// Concurrent checks on the converter core control bank's ports.
// Assumes it is bound into the bank and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_consts.svh"
module ccr_core_ctrl_checker (
   input  wire logic        clk_in,                 // Clock
   input  wire logic        sys_rst_in,             // Async reset, high
   input  wire logic        avs_read_in,            // Read request
   input  wire logic        avs_write_in,           // Write request
   input  wire logic        avs_waitrequest_out,    // Stall
   input  wire logic [1:0]  core_run_out,           // Core running
   input  wire logic [1:0]  core_output_bleed_out,  // Discharge path on
   input  wire logic [1:0]  core_fixed_freq_out,    // Forced fixed freq
   input  wire logic [1:0]  core_floor_sel_out,     // Floor state
   input  wire logic [15:0] core_target_vset_out,   // Target codes
   input  wire logic [7:0]  core_cap_half_amps_out, // Current caps
   input  wire logic [23:0] core_ramp_rate_out      // Ramp rates
);
   wire acc = avs_write_in & ~avs_waitrequest_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_wait_one: assert property ((avs_read_in || avs_write_in)
      && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait state longer than one cycle");
   a_bleed_idle_two: assert property (core_output_bleed_out[0]
      |-> !core_run_out[0]) else $error("core two bleeds while running");
   a_bleed_idle_three: assert property (core_output_bleed_out[1]
      |-> !core_run_out[1]) else $error("core three bleeds while running");
   a_floor_keeps_run: assert property (core_floor_sel_out[0]
      |-> core_run_out[0]) else $error("floor state stopped the core");
   a_cap_in_range: assert property (!$past(sys_rst_in)
      |-> core_cap_half_amps_out[3:0] inside {[4'h5:4'ha]})
      else $error("current cap outside its range");
   a_ramp_in_table: assert property (!$past(sys_rst_in)
      |-> core_ramp_rate_out[11:0] inside {`CCR_RAMP_C0, `CCR_RAMP_C1,
      `CCR_RAMP_C2, `CCR_RAMP_C3, `CCR_RAMP_C4, `CCR_RAMP_C5,
      `CCR_RAMP_C6, `CCR_RAMP_C7}) else $error("ramp rate not in table");
   a_freq_after_write: assert property (!$past(sys_rst_in, 2)
      && $changed(core_fixed_freq_out) |-> $past(acc, 2))
      else $error("fixed freq moved without a write");
   a_cap_after_write: assert property (!$past(sys_rst_in, 2)
      && $changed(core_cap_half_amps_out) |-> $past(acc, 2))
      else $error("current cap moved without a write");
   a_vset_after_cause: assert property (!$past(sys_rst_in, 2)
      && $changed(core_target_vset_out)
      |-> $past(acc, 2) || $changed(core_floor_sel_out))
      else $error("target moved without a cause");
endmodule : ccr_core_ctrl_checker
`default_nettype wire

// ### sim/ccr_host_model.sv
// Avalon-MM master standing in for the host processor.
// Assumes one clock shared with the register bank.
`timescale 1ns/1ns
`default_nettype none
module ccr_host_model (
   input  wire logic        clk_in,     // Bus clock
   input  wire logic        waitreq_in, // Slave stall
   input  wire logic [31:0] rdata_in,   // Read data
   input  wire logic [1:0]  resp_in,    // Response code
   output logic [7:0]       addr_out,   // Word address
   output logic             read_out,   // Read request
   output logic             write_out,  // Write request
   output logic [31:0]     wdata_out,   // Write data
   output logic [3:0]       be_out      // Byte enables
);
   initial begin
      addr_out = 8'h00;
      read_out = 1'b0;
      write_out = 1'b0;
      wdata_out = 32'h00000000;
      be_out = 4'h1;
   end
   // Stall and read data are read in the active region of a rising
   // edge, so they are the values the slave showed before that edge
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic b, output logic [7:0] q, output logic [1:0] r);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= {24'h000000, d};
      be_out <= {3'b000, b};
      write_out <= w;
      read_out <= ~w;
      @(posedge clk_in);
      while (waitreq_in) @(posedge clk_in);
      q = rdata_in[7:0];
      r = resp_in;
      write_out <= 1'b0;
      read_out <= 1'b0;
   endtask : xfer
endmodule : ccr_host_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the converter core control bank.
// Assumes the host model drives the bus and this module the pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_in, sys_rst_in, en1, en2, rd, wr_s, wreq;
   logic [7:0]  addr, cap;
   logic [31:0] wdat, rdat;
   logic [3:0]  be;
   logic [1:0]  resp, run, bleed, fixd, flr;
   logic [15:0] vset;
   logic [23:0] ramp;
   int fails, n_compared;
   logic [11:0] rt [8] = '{12'hbb8, 12'h5dc, 12'h3e8, 12'h2ee,
                           12'h17c, 12'h0be, 12'h05e, 12'h028};
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   ccr_host_model host (.clk_in(clk_in), .waitreq_in(wreq),
      .rdata_in(rdat), .resp_in(resp), .addr_out(addr), .read_out(rd),
      .write_out(wr_s), .wdata_out(wdat), .be_out(be));
   ccr_core_ctrl uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr_s),
      .avs_writedata_in(wdat), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .avs_response_out(resp), .enable_input_first_in(en1),
      .enable_input_second_in(en2), .core_run_out(run),
      .core_output_bleed_out(bleed), .core_fixed_freq_out(fixd),
      .core_floor_sel_out(flr), .core_target_vset_out(vset),
      .core_cap_half_amps_out(cap), .core_ramp_rate_out(ramp));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task settle();
      repeat (2) @(negedge clk_in);
   endtask : settle
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic [1:0] r;
      host.xfer(1'b1, a, d, 1'b1, q, r);
      settle();
   endtask : wr
   task rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] s);
      logic [7:0] q;
      logic [1:0] r;
      host.xfer(1'b0, a, 8'h00, 1'b1, q, r);
      chk(q, e);
      chk(r, s);
   endtask : rdc
   task pins(input logic f, input logic s);
      @(posedge clk_in);
      en1 <= f;
      en2 <= s;
      settle();
   endtask : pins
   task t_reset();
      chk(run, 2'b11);
      chk(bleed, 2'b00);
      chk(cap, 8'h99);
      chk(ramp, {2{12'h17c}});
      chk(fixd, 2'b00);
      chk(vset, 16'h3737);
      rdc(8'h06, 8'he8, 2'b00);
      rdc(8'h07, 8'h34, 2'b00);
      rdc(8'h08, 8'he8, 2'b00);
      rdc(8'h09, 8'h34, 2'b00);
      rdc(8'h10, 8'h37, 2'b00);
      rdc(8'h11, 8'h00, 2'b00);
   endtask : t_reset
   task t_pins();
      pins(1'b0, 1'b0);
      chk(run, 2'b00);
      chk(bleed, 2'b11);
      wr(8'h06, 8'hca);
      pins(1'b1, 1'b0);
      chk(run, 2'b01);
   endtask : t_pins
   task t_floor();
      wr(8'h0e, 8'h40);
      wr(8'h0f, 8'h12);
      wr(8'h06, 8'hd8);
      pins(1'b0, 1'b0);
      chk(flr, 2'b01);
      chk(run, 2'b01);
      chk(vset[7:0], 8'h12);
      pins(1'b1, 1'b0);
      chk(flr, 2'b00);
      chk(vset[7:0], 8'h40);
   endtask : t_floor
   task t_fixed();
      wr(8'h06, 8'h82);
      pins(1'b0, 1'b0);
      chk(run, 2'b01);
      chk(fixd, 2'b01);
      wr(8'h06, 8'h00);
      chk(run, 2'b00);
      chk(bleed, 2'b10);
   endtask : t_fixed
   task t_codes();
      logic [2:0] c;
      pins(1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(8'h09, {2'b00, c, c});
         chk(run[1], 1'b1);
         chk(ramp[23:12], rt[i]);
         if (i >= 2) begin
            chk(cap[7:4], {1'b0, c} + 4'h3);
         end else begin
            chk(cap[7:4], 4'h5);
         end
      end
   endtask : t_codes
   task t_regs();
      logic [7:0] q;
      logic [1:0] r;
      wr(8'h08, 8'hfa);
      rdc(8'h08, 8'hfa, 2'b00);
      pins(1'b0, 1'b0);
      chk(flr, 2'b10);
      chk(vset[15:8], 8'h00);
      chk(fixd, 2'b10);
      wr(8'h09, 8'h3f);
      rdc(8'h09, 8'h3f, 2'b00);
      // Byte lane zero disabled: the write must be dropped
      host.xfer(1'b1, 8'h09, 8'h00, 1'b0, q, r);
      settle();
      rdc(8'h09, 8'h3f, 2'b00);
      rdc(8'h20, 8'h00, 2'b11);
   endtask : t_regs
   task t_rerst();
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      settle();
      chk(run, 2'b00);
      rdc(8'h06, 8'he8, 2'b00);
      rdc(8'h09, 8'h34, 2'b00);
   endtask : t_rerst
   task conclude();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (2000) @(posedge clk_in);
      fails++;
      conclude();
   end
   initial begin
      sys_rst_in = 1'b1;
      en1 = 1'b0;
      en2 = 1'b1;
      fails = 0;
      n_compared = 0;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      settle();
      t_reset();
      t_pins();
      t_floor();
      t_fixed();
      t_codes();
      t_regs();
      t_rerst();
      conclude();
   end
endmodule : tb_top
bind ccr_core_ctrl ccr_core_ctrl_checker chk_i (.clk_in(clk_in),
   .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .core_run_out(core_run_out), .core_output_bleed_out(core_output_bleed_out),
   .core_fixed_freq_out(core_fixed_freq_out),
   .core_floor_sel_out(core_floor_sel_out),
   .core_target_vset_out(core_target_vset_out),
   .core_cap_half_amps_out(core_cap_half_amps_out),
   .core_ramp_rate_out(core_ramp_rate_out));
`default_nettype wire
